// ### bench/rbp_drv_model.sv
// Gate driver and tank current comparator model
`timescale 1ns/1ps
module rbp_drv_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] gate,
    input  wire logic       zc_en,
    input  wire logic [3:0] zc_dly,
    output logic            cmp_pos_hi,
    output logic            cmp_neg_lo
);
    logic [7:0] age_p;
    logic [7:0] age_n;
    // Tank current builds while a primary pulse stands, back at zero once the pulse has stood for zc_dly + 1 cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            age_p <= 8'h00;
            age_n <= 8'h00;
        end else begin
            age_p <= !gate[7] ? 8'h00 : (age_p == 8'hFF ? age_p : age_p + 8'h01);
            age_n <= !gate[5] ? 8'h00 : (age_n == 8'hFF ? age_n : age_n + 8'h01);
        end
    end
    // Separate zero-current flags for each half-cycle
    assign cmp_pos_hi = zc_en && (age_p > {4'h0, zc_dly});
    assign cmp_neg_lo = zc_en && (age_n > {4'h0, zc_dly});
endmodule

// ### bench/tb.sv
// Self-checking bench for the resonant bridge modulator
`timescale 1ns/1ps
`include "rbp_regs.svh"
module tb;
    logic        clk_sys      = 1'b0;
    logic        rst          = 1'b1;
    logic [3:0]  addr         = 4'h0;
    logic [15:0] wdata        = 16'h0000;
    logic        wr           = 1'b0;
    logic        rd           = 1'b0;
    logic        cmp_aux      = 1'b0;
    logic [11:0] prim_current = 12'h800;
    logic        zc_en        = 1'b0;
    logic [3:0]  zc_dly       = 4'h3;
    logic [15:0] rdata;
    logic        cmp_pos_hi;
    logic        cmp_neg_lo;
    logic [7:0]  gate;
    logic [15:0] rv;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    int          overlap      = 0;
    int          h0, h1, h2, h3;
    logic [3:0]  ra [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'hC, 4'hD};
    logic [15:0] rx [12] = '{`RBP_CTRL_RST, `RBP_PRD_RST, `RBP_PRD_RST, `RBP_PRD_RST,
        `RBP_PRD_RST, {8'h00, `RBP_DEAD_RST}, `RBP_SECPH_RST, {8'h00, `RBP_BLANK_RST},
        `RBP_DUTY_RST, {4'h0, `RBP_OCLIM_HI_RST}, {12'h000, `RBP_XBAR_RST},
        {4'h0, `RBP_OCLIM_LO_RST}};

    always #10 clk_sys = ~clk_sys;

    rbp_top u_rbp_top (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cmp_pos_hi(cmp_pos_hi), .cmp_neg_lo(cmp_neg_lo),
        .cmp_aux(cmp_aux), .prim_current(prim_current), .gate(gate));
    rbp_drv_model u_rbp_drv_model (.clk_sys(clk_sys), .rst(rst), .gate(gate), .zc_en(zc_en),
        .zc_dly(zc_dly), .cmp_pos_hi(cmp_pos_hi), .cmp_neg_lo(cmp_neg_lo));

    // Shoot-through and bridge diagonal overlap watch
    always @(posedge clk_sys) begin
        if (!rst && (((gate[7] & gate[6]) | (gate[5] & gate[4]) | (gate[3] & gate[2])
            | (gate[1] & gate[0]) | (gate[7] & gate[5])) === 1'b1)) begin
            overlap++;
        end
    end

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic expect_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        logic [15:0] v;
        rd_reg(a, v);
        check16(what, exp, v);
    endtask

    task automatic count_hi(input int b, input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge clk_sys);
            #1;
            if (gate[b] === 1'b1) n++;
        end
    endtask

    task automatic wait_off();
        int k;
        k = 0;
        repeat (5) @(posedge clk_sys);
        #1;
        while (gate !== 8'h00 && k < 16) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        check16("gate after overcurrent", 16'h0000, {8'h00, gate});
    endtask

    task automatic summarize();
        $display("CHECKS %0d MISMATCHES %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        $display("ERROR watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) expect_rd(ra[i], rx[i], "reset value");
        $display("TEST reset values done");
        wr_reg(4'h0, 16'h0003);
        wr_reg(4'h1, 16'h0040);
        for (int i = 2; i < 5; i++) expect_rd(i[3:0], 16'h0040, "linked period");
        wr_reg(4'h0, 16'h0001);
        wr_reg(4'h1, 16'h0032);
        expect_rd(4'h2, 16'h0040, "unlinked period");
        wr_reg(4'h0, 16'h0003);
        wr_reg(4'h1, 16'h0032);
        wr_reg(4'h0, 16'h0001);
        wr_reg(4'hA, 16'h0001);
        $display("TEST period link done");
        count_hi(7, 400, h0);
        count_hi(6, 400, h1);
        count_hi(5, 400, h2);
        check1("primary high active", 1'b1, h0 > 0);
        check1("primary low active", 1'b1, h1 > 0);
        check1("second leg active", 1'b1, h2 > 0);
        $display("TEST modulation done");
        count_hi(3, 400, h0);
        count_hi(0, 400, h2);
        @(posedge clk_sys);
        zc_en <= 1'b1;
        count_hi(3, 400, h1);
        count_hi(0, 400, h3);
        check1("positive trip shortens pulse", 1'b1, h1 < h0);
        check1("negative trip shortens pulse", 1'b1, h3 < h2);
        check1("rectifier still starts", 1'b1, h1 > 0);
        @(posedge clk_sys);
        zc_en <= 1'b0;
        $display("TEST rectifier trip done");
        prim_current <= 12'hD00;
        wait_off();
        rd_reg(4'hB, rv);
        check1("overcurrent flag", 1'b1, rv[2]);
        @(posedge clk_sys);
        prim_current <= 12'h800;
        wr_reg(4'h0, 16'h0009);
        count_hi(7, 200, h0);
        check1("restart after clear", 1'b1, h0 > 0);
        @(posedge clk_sys);
        prim_current <= 12'h300;
        wait_off();
        wr_reg(4'hE, 16'h0100);
        expect_rd(4'hD, 16'h0100, "low limit via spare address");
        wr_reg(4'h0, 16'h0009);
        count_hi(7, 200, h0);
        check1("window moved down", 1'b1, h0 > 0);
        $display("TEST overcurrent done");
        wr_reg(4'h0, 16'h0005);
        count_hi(3, 400, h0);
        check1("reverse flow drive", 1'b1, h0 > 0);
        check16("overlap count", 16'h0000, overlap[15:0]);
        $display("TEST reverse flow done");
        summarize();
    end
endmodule

// ### hw/rbp_dead.sv
// Complementary pair generation with programmable dead time
`timescale 1ns/1ps
module rbp_dead
    import rbp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       raw,
    input  wire logic [7:0] dead,
    output rbp_pair_s       pair
);
    typedef struct packed {
        logic       prev;
        logic [7:0] dly;
        rbp_pair_s  out;
    } rbp_dead_st_s;
    rbp_dead_st_s st_r;
    rbp_dead_st_s st_nxt;

    assign pair = st_r.out;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = raw;
        // Both off during the dead gap, then complement [R3]
        if (raw != st_r.prev) begin
            st_nxt.dly    = dead;
            st_nxt.out.hi = 1'b0;
            st_nxt.out.lo = 1'b0;
        end else if (st_r.dly != 8'h00) begin
            st_nxt.dly = st_r.dly - 8'h01;
        end else begin
            st_nxt.out.hi = raw;
            st_nxt.out.lo = !raw;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ### hw/rbp_leg.sv
// One leg time base with fine placement; the dead input is unused here, dead time is applied in rbp_dead
`timescale 1ns/1ps
`include "rbp_regs.svh"
module rbp_leg
    import rbp_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      rst,
    input  wire logic      run,
    input  wire logic      sync,
    input  wire rbp_cnt_t  prd,
    input  wire rbp_cnt_t  start,
    input  wire rbp_cnt_t  cmp,
    input  wire logic [3:0] fine,
    input  wire logic [7:0] dead,
    output rbp_cnt_t       cnt,
    output rbp_dir_e       dir,
    output logic           zero_ev,
    output logic           prd_ev,
    output logic           raw
);
    typedef struct packed {
        rbp_cnt_t   cnt;
        rbp_dir_e   dir;
        logic [4:0] acc;
        logic       ext;
    } rbp_leg_st_s;
    rbp_leg_st_s st_r;
    rbp_leg_st_s st_nxt;
    logic [4:0]  acc_sum;

    assign cnt     = st_r.cnt;
    assign dir     = st_r.dir;
    assign zero_ev = run && (st_r.cnt == 16'h0000) && (st_r.dir == RBP_DOWN);
    assign prd_ev  = run && (st_r.cnt == prd) && (st_r.dir == RBP_UP);
    // Pulse centred on the top of count; fine remainder stretches one cycle
    assign raw     = run && ((st_r.cnt >= cmp) || st_r.ext);   // [R2]
    assign acc_sum = st_r.acc + {1'b0, fine};

    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt = '0;
        end else if (sync) begin
            st_nxt.cnt = start;
            st_nxt.dir = RBP_UP;
        end else begin
            // Up then down each period [R1]
            if (st_r.dir == RBP_UP) begin
                if (st_r.cnt >= prd) begin
                    st_nxt.dir = RBP_DOWN;
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end else begin
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end
            end else begin
                if (st_r.cnt == 16'h0000) begin
                    st_nxt.dir = RBP_UP;
                    st_nxt.cnt = 16'h0001;
                end else begin
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end
            end
            // Remainder carried forward each period [R1] [R15]
            st_nxt.ext = 1'b0;
            if (zero_ev) begin
                st_nxt.acc = {1'b0, acc_sum[3:0]};
            end
            if (st_r.dir == RBP_DOWN && st_r.cnt == cmp && acc_sum[4]) begin
                st_nxt.ext = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ### hw/rbp_pkg.sv
// Types shared by the resonant bridge modulator
package rbp_pkg;
    typedef logic [15:0] rbp_cnt_t;
    typedef enum logic {RBP_UP, RBP_DOWN} rbp_dir_e;
    typedef struct packed {
        logic hi;
        logic lo;
    } rbp_pair_s;
    typedef struct packed {
        logic pos_trip;
        logic neg_trip;
        logic oc_trip;
    } rbp_trip_s;
endpackage

// ### hw/rbp_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RBP_REGS_SVH
`define RBP_REGS_SVH
`define RBP_ADDR_W          4
`define RBP_OFS_CTRL        4'h0
`define RBP_OFS_PRD0        4'h1
`define RBP_OFS_PRD1        4'h2
`define RBP_OFS_PRD2        4'h3
`define RBP_OFS_PRD3        4'h4
`define RBP_OFS_DEAD        4'h5
`define RBP_OFS_SECPH       4'h6
`define RBP_OFS_BLANK       4'h7
`define RBP_OFS_DUTY        4'h8
`define RBP_OFS_OCLIM       4'h9
`define RBP_OFS_SYNC        4'hA
`define RBP_OFS_STAT        4'hB
`define RBP_OFS_XBAR        4'hC
`define RBP_CTRL_EN         0
`define RBP_CTRL_LINK       1
`define RBP_CTRL_REV        2
`define RBP_CTRL_OCCLR      3
`define RBP_CTRL_RST        16'h0000
`define RBP_PRD_RST         16'h0032
`define RBP_DEAD_RST        8'h02
`define RBP_BLANK_RST       8'h03
`define RBP_DUTY_RST        16'h0019
`define RBP_SECPH_RST       16'h0004
`define RBP_OCLIM_HI_RST    12'hC00
`define RBP_OCLIM_LO_RST    12'h400
`define RBP_XBAR_RST        4'h3
`define RBP_FINE_W          4
`endif

// ### hw/rbp_top.sv
// Resonant bridge modulator with synchronous rectification and trips
//
// Functional notes
// [R1] All four legs count up then down, with fine edge placement.
// [R2] First primary high pulse is centred on the top-of-count event.
// [R3] Low drive is the dead-time separated complement of high drive.
// [R4] Second primary leg runs half a period opposite the first.
// [R5] That offset comes from swapping the channel outputs, not phase.
// [R6] Secondary legs start at a programmable offset: period plus isolator delay.
// [R7] Rectifier pulse starts at an instant set by primary timing.
// [R8] Rectifier pulse ends on zero-current trip.
// [R9] Zero-current trip stays latched until next zero or period event.
// [R10] Blanking window around switching instants suppresses trips.
// [R11] Comparator stage does latching and blanking; takes only blank pulse.
// [R12] Separate positive and negative trips routed through a crossbar.
// [R13] Positive trip ends output A counting up; negative ends B counting down.
// [R14] With linking on, one period write updates all four legs.
// [R15] Software must not resync every period; remainder carries forward.
// [R16] Software issues one sync pulse on each frequency or duty change.
// [R17] Windowed overcurrent compare trips outputs directly.
// [R18] Crossbar combines several comparator sources into trip events.
// [R19] Reverse flow swaps primary and secondary roles.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "rbp_regs.svh"
module rbp_top
    import rbp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    input  wire logic        cmp_pos_hi,
    input  wire logic        cmp_neg_lo,
    input  wire logic        cmp_aux,
    input  wire logic [11:0] prim_current,
    output logic [7:0]       gate
);
    typedef struct packed {
        logic [15:0] ctrl;
        rbp_cnt_t [3:0] prd;
        logic [7:0]  dead;
        rbp_cnt_t    secph;
        logic [7:0]  blank;
        rbp_cnt_t    duty;
        logic [11:0] oc_hi;
        logic [11:0] oc_lo;
        logic [3:0]  fine;
        logic [3:0]  xbar;
        logic        sync;
        logic        pos_lat;
        logic        neg_lat;
        logic        oc_lat;
        logic [2:0]  m1;
        logic [2:0]  m2;
        logic [11:0] cur1;
        logic [11:0] cur2;
        logic [15:0] rdata;
        logic [7:0]  gate;
    } rbp_top_st_s;
    rbp_top_st_s st_r;
    rbp_top_st_s st_nxt;

    rbp_cnt_t  cnt    [4];
    rbp_dir_e  dir    [4];
    logic [3:0] zev;
    logic [3:0] pev;
    logic [3:0] raw;
    rbp_pair_s pair   [4];
    rbp_cnt_t  start  [4];
    rbp_cnt_t  cmpv   [4];
    logic       run;
    logic       blank_win;
    rbp_trip_s  trip;
    logic       pos_x;
    logic       neg_x;
    logic       sec_a;
    logic       sec_b;
    logic [7:0] gate_c;

    assign run = st_r.ctrl[`RBP_CTRL_EN];

    // Secondary legs start ahead by the programmed offset [R6] [R7]
    assign start[0] = 16'h0000;
    assign start[1] = 16'h0000;
    assign start[2] = st_r.secph;
    assign start[3] = st_r.secph;
    assign cmpv[0]  = st_r.duty;
    assign cmpv[1]  = st_r.duty;
    assign cmpv[2]  = st_r.duty;
    assign cmpv[3]  = st_r.duty;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_leg
            rbp_leg u_leg (
                .clk_sys (clk_sys),
                .rst     (rst),
                .run     (run),
                .sync    (st_r.sync),
                .prd     (st_r.prd[gi]),
                .start   (start[gi]),
                .cmp     (cmpv[gi]),
                .fine    (st_r.fine),
                .dead    (st_r.dead),
                .cnt     (cnt[gi]),
                .dir     (dir[gi]),
                .zero_ev (zev[gi]),
                .prd_ev  (pev[gi]),
                .raw     (raw[gi])
            );
            rbp_dead u_dead (
                .clk_sys (clk_sys),
                .rst     (rst),
                .raw     (raw[gi]),
                .dead    (st_r.dead),
                .pair    (pair[gi])
            );
        end
    endgenerate

    // Blanking window from the secondary time base [R10] [R11]
    assign blank_win = (cnt[2] < {8'h00, st_r.blank})
                     || (cnt[2] + {8'h00, st_r.blank} >= st_r.prd[2]);

    // Crossbar selects and combines comparator sources [R12] [R18]
    assign pos_x = st_r.xbar[0] ? st_r.m1[2] : (st_r.m1[2] | st_r.m2[2]);
    assign neg_x = st_r.xbar[1] ? st_r.m2[2] : (st_r.m1[2] & st_r.m2[2]);
    assign trip.pos_trip = st_r.pos_lat;
    assign trip.neg_trip = st_r.neg_lat;
    assign trip.oc_trip  = st_r.oc_lat;

    // Trip ends A on up count, B on down count [R8] [R13]
    assign sec_a = pair[2].hi && !(trip.pos_trip && dir[2] == RBP_UP);
    assign sec_b = pair[2].lo && !(trip.neg_trip && dir[2] == RBP_DOWN);

    always_comb begin
        gate_c = {pair[0].hi, pair[0].lo,
                  pair[1].lo, pair[1].hi,                   // [R4] [R5]
                  sec_a, sec_b, sec_a, sec_b};
        if (st_r.ctrl[`RBP_CTRL_REV]) begin
            gate_c = {sec_a, sec_b, sec_b, sec_a,           // [R19]
                      pair[0].hi, pair[0].lo, pair[1].lo, pair[1].hi};
        end
        if (trip.oc_trip || !run) begin
            gate_c = 8'h00;                                 // [R17]
        end
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.sync = 1'b0;
        st_nxt.m1   = {st_r.m1[1:0], cmp_pos_hi};
        st_nxt.m2   = {st_r.m2[1:0], cmp_neg_lo};
        st_nxt.cur1 = prim_current;
        st_nxt.cur2 = st_r.cur1;
        st_nxt.gate = gate_c;
        // Latched zero-current trips, released on zero or period [R9]
        if (zev[2] || pev[2]) begin
            st_nxt.pos_lat = 1'b0;
            st_nxt.neg_lat = 1'b0;
        end
        if (!blank_win && pos_x) begin
            st_nxt.pos_lat = 1'b1;                          // [R8] [R10]
        end
        if (!blank_win && neg_x) begin
            st_nxt.neg_lat = 1'b1;
        end
        // Window overcurrent compare, set wins over clear [R17]
        if (st_r.ctrl[`RBP_CTRL_OCCLR]) begin
            st_nxt.oc_lat = 1'b0;
            st_nxt.ctrl[`RBP_CTRL_OCCLR] = 1'b0;
        end
        if (run && (st_r.cur2 > st_r.oc_hi || st_r.cur2 < st_r.oc_lo
            || (st_r.xbar[2] && st_r.m1[2] && st_r.m2[2]))) begin
            st_nxt.oc_lat = 1'b1;                           // [R18]
        end
        if (wr) begin
            unique case (addr)
                `RBP_OFS_CTRL:  st_nxt.ctrl = wdata;
                `RBP_OFS_PRD0: begin
                    st_nxt.prd[0] = wdata;
                    if (st_r.ctrl[`RBP_CTRL_LINK]) begin
                        st_nxt.prd = {4{wdata}};             // [R14]
                    end
                end
                `RBP_OFS_PRD1:  st_nxt.prd[1] = wdata;
                `RBP_OFS_PRD2:  st_nxt.prd[2] = wdata;
                `RBP_OFS_PRD3:  st_nxt.prd[3] = wdata;
                `RBP_OFS_DEAD:  st_nxt.dead  = wdata[7:0];
                `RBP_OFS_SECPH: st_nxt.secph = wdata;
                `RBP_OFS_BLANK: st_nxt.blank = wdata[7:0];
                `RBP_OFS_DUTY: begin
                    st_nxt.duty = wdata;
                    st_nxt.fine = wdata[15:12];
                end
                `RBP_OFS_OCLIM: st_nxt.oc_hi = wdata[11:0];
                `RBP_OFS_SYNC:  st_nxt.sync  = wdata[0];     // [R16]
                `RBP_OFS_XBAR:  st_nxt.xbar  = wdata[3:0];
                `RBP_OFS_STAT:  st_nxt.oc_lo = st_r.oc_lo;
                default:        st_nxt.oc_lo = wdata[11:0];
            endcase
        end
        st_nxt.rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                `RBP_OFS_CTRL:  st_nxt.rdata = st_r.ctrl;
                `RBP_OFS_PRD0:  st_nxt.rdata = st_r.prd[0];
                `RBP_OFS_PRD1:  st_nxt.rdata = st_r.prd[1];
                `RBP_OFS_PRD2:  st_nxt.rdata = st_r.prd[2];
                `RBP_OFS_PRD3:  st_nxt.rdata = st_r.prd[3];
                `RBP_OFS_DEAD:  st_nxt.rdata = {8'h00, st_r.dead};
                `RBP_OFS_SECPH: st_nxt.rdata = st_r.secph;
                `RBP_OFS_BLANK: st_nxt.rdata = {8'h00, st_r.blank};
                `RBP_OFS_DUTY:  st_nxt.rdata = st_r.duty;
                `RBP_OFS_OCLIM: st_nxt.rdata = {4'h0, st_r.oc_hi};
                `RBP_OFS_STAT:  st_nxt.rdata = {13'h0000, st_r.oc_lat,
                                                st_r.neg_lat, st_r.pos_lat};
                `RBP_OFS_XBAR:  st_nxt.rdata = {12'h000, st_r.xbar};
                default:        st_nxt.rdata = {4'h0, st_r.oc_lo};
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r       <= '0;
            st_r.prd   <= {4{`RBP_PRD_RST}};
            st_r.dead  <= `RBP_DEAD_RST;
            st_r.blank <= `RBP_BLANK_RST;
            st_r.duty  <= `RBP_DUTY_RST;
            st_r.secph <= `RBP_SECPH_RST;
            st_r.oc_hi <= `RBP_OCLIM_HI_RST;
            st_r.oc_lo <= `RBP_OCLIM_LO_RST;
            st_r.xbar  <= `RBP_XBAR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign gate  = st_r.gate;

    chk_link_write: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        (wr && addr == `RBP_OFS_PRD0 && st_r.ctrl[`RBP_CTRL_LINK])
        |=> (st_r.prd[3] == $past(wdata) && st_r.prd[1] == $past(wdata)))
        else $error("linked period write missed a leg");
    chk_oc_gate: assert property (@(posedge clk_sys) disable iff (rst) // [R17]
        st_r.oc_lat |=> gate == 8'h00)
        else $error("gates active during overcurrent");
    chk_trip_hold: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        (st_r.pos_lat && !zev[2] && !pev[2]) |=> st_r.pos_lat)
        else $error("trip released early");
    chk_blank_sup: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
        (blank_win && !st_r.pos_lat) |=> !st_r.pos_lat)
        else $error("trip set inside blanking");
    chk_trip_a: assert property (@(posedge clk_sys) disable iff (rst) // [R13]
        (trip.pos_trip && dir[2] == RBP_UP) |-> !sec_a)
        else $error("output A not ended by trip");
    chk_trip_b: assert property (@(posedge clk_sys) disable iff (rst) // [R13]
        (trip.neg_trip && dir[2] == RBP_DOWN) |-> !sec_b)
        else $error("output B not ended by trip");
    chk_no_shoot: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        !(pair[0].hi && pair[0].lo))
        else $error("complementary overlap");
    chk_swap_leg: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        (!st_r.ctrl[`RBP_CTRL_REV] && run && !st_r.oc_lat)
        |=> gate[5] == $past(pair[1].lo))
        else $error("second leg not swapped");
endmodule
